/* File: design/csf_oam_framer.sv */
/*
  Client-signal-fail framer for one point-to-point down end point:
  sends periodic fault PDUs while the ingress client link is down,
  and turns received PDUs into a remote fault on the egress port.
  Assumes the link framing around the PDU bytes is added outside,
  and that the end point up/down states come from the fault manager.
*/
// Contract
// - PDU carries sender's 3-bit level
// - Version 0, opcode 52 marks PDU
// - Flags hold defect and period fields
// - Defect codes LOS, FDI, RDI, DCI
// - Only 1 second or 1 minute periods
// - Never emit invalid or reserved periods
// - TLV offset field always zero
// - PDU ends with all-zero octet
// - Send only while both end points up (a frame already started still finishes)
// - Aggregated client: timeout 3.5 configured intervals
// - Up to 8k instances, one port each
// - Link fault starts sending at once
// - Clearance by silence or DCI PDU
// - Non-clear PDU forces egress port down
// - DCI or 3.5-period silence clears fault
`default_nettype none

module csf_oam_framer import csf_pkg::*; #(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEFAULT
) (
  input wire logic clock,
  input wire logic rst_n,
  // Configuration
  input wire logic csf_enable, // Transmission allowed
  input wire logic [2:0] local_level, // Maintenance level
  input wire logic [2:0] defect_cfg, // Fault type to send
  input wire logic period_minute, // 1: one a minute
  input wire logic dci_on_clear, // Send a clear PDU on recovery
  input wire logic client_is_lag, // Client is an aggregated port
  input wire logic [12:0] instance_id, // End point instance
  // Status inputs
  input wire logic client_link_up,
  input wire logic local_mep_up,
  input wire logic remote_mep_up,
  // Transmit stream
  output logic tx_valid,
  output byte_beat_type tx_beat,
  output logic [12:0] tx_instance,
  input wire logic tx_ready,
  // Receive stream
  input wire logic rx_valid,
  input wire byte_beat_type rx_beat,
  // Egress client control
  output logic remote_fault,
  output logic egress_oper_up
);

  // ----------------------------------------------------------------
  // Millisecond tick
  // ----------------------------------------------------------------
  logic [TICK_CNT_W-1:0] tick_cnt_q, tick_cnt_d; // Cycle count in tick
  logic tick; // One-cycle pulse each millisecond

  // Free-running divider, shared by both timers
  always_comb begin
    tick = tick_cnt_q == TICK_CNT_W'(TICK_CYCLES - 1);
    if (tick) begin
      tick_cnt_d = '0;
    end else begin
      tick_cnt_d = tick_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // Local fault tracking and send requests
  // ----------------------------------------------------------------
  logic local_fault; // Client link down while enabled
  logic both_up; // Both end points healthy
  logic fault_q, fault_d; // Last cycle's local fault
  logic req_q, req_d; // A PDU is owed
  logic dci_q, dci_d; // The owed PDU is a clear
  logic [TIMER_W-1:0] per_cnt_q, per_cnt_d; // Ticks into period
  logic [TIMER_W-1:0] cfg_period; // Configured period
  logic [TIMER_W-1:0] cfg_timeout; // 3.5 configured periods
  logic tx_start; // Sequencer takes the request

  assign local_fault = csf_enable & ~client_link_up;
  assign both_up = local_mep_up & remote_mep_up;
  assign cfg_period = period_minute ? PERIOD_MIN_MS : PERIOD_SEC_MS;
  assign cfg_timeout = period_minute ? TIMEOUT_MIN_MS : TIMEOUT_SEC_MS;

  // Period timer; a set arriving with a take is kept
  always_comb begin
    fault_d = local_fault;
    per_cnt_d = per_cnt_q;
    req_d = req_q;
    dci_d = dci_q;
    // Taken requests clear first so new events win
    if (tx_start) begin
      req_d = 1'b0;
      dci_d = 1'b0;
    end
    if (!local_fault) begin
      per_cnt_d = '0;
      // Recovery: stop, or send one clear PDU
      if (fault_q && dci_on_clear && csf_enable) begin
        req_d = 1'b1;
        dci_d = 1'b1;
      end
    end else if (!fault_q) begin
      // First PDU goes out without waiting a period
      per_cnt_d = '0;
      req_d = 1'b1;
      dci_d = 1'b0;
    end else if (tick) begin
      if (per_cnt_q >= cfg_period - 1'b1) begin
        per_cnt_d = '0;
        req_d = 1'b1;
      end else begin
        per_cnt_d = per_cnt_q + 1'b1;
      end
    end
    // An end point failure drops anything owed
    if (!both_up) begin
      req_d = 1'b0;
      dci_d = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fault_q <= 1'b0;
      req_q <= 1'b0;
      dci_q <= 1'b0;
      per_cnt_q <= '0;
    end else begin
      fault_q <= fault_d;
      req_q <= req_d;
      dci_q <= dci_d;
      per_cnt_q <= per_cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // Transmit sequencer
  // ----------------------------------------------------------------
  tx_state_type tx_state_q, tx_state_d; // Sequencer state
  logic [8*PDU_BYTES-1:0] frame_q, frame_d; // Bytes still to send
  logic [2:0] tx_idx_q, tx_idx_d; // Byte being offered
  logic [12:0] inst_q, inst_d; // Instance tag of frame
  csf_flags_type tx_flags; // Flags of the next PDU
  logic [2:0] tx_defect; // Defect code to send

  // Unknown configured types fall back to loss of signal
  always_comb begin
    if (dci_q) begin
      tx_defect = DEFECT_DCI;
    end else if (defect_cfg == DEFECT_FDI || defect_cfg == DEFECT_RDI) begin
      tx_defect = defect_cfg;
    end else begin
      tx_defect = DEFECT_LOS;
    end
    tx_flags.spare_hi = 1'b0;
    tx_flags.defect = tx_defect;
    // Only the two defined codes can ever be built
    tx_flags.period = period_minute ? PERIOD_CODE_MIN : PERIOD_CODE_SEC;
    tx_flags.spare_lo = 1'b0;
  end

  assign tx_start = tx_state_q == TX_IDLE && req_q && both_up;

  // Frame build and byte walk
  always_comb begin
    tx_state_d = tx_state_q;
    frame_d = frame_q;
    tx_idx_d = tx_idx_q;
    inst_d = inst_q;
    unique case (tx_state_q)
      TX_IDLE: begin
        if (tx_start) begin
          // The whole PDU is frozen here, so mid-frame
          // configuration changes cannot tear it
          frame_d = {local_level, PDU_VERSION,
                     PDU_OPCODE,
                     tx_flags,
                     PDU_TLV_OFFSET,
                     PDU_END_TLV};
          inst_d = instance_id;
          tx_idx_d = 3'h0;
          tx_state_d = TX_SEND;
        end
      end
      TX_SEND: begin
        // A started frame finishes; cutting it would leave
        // a runt on the wire. Only new frames are held off.
        if (tx_ready) begin
          frame_d = {frame_q[8*PDU_BYTES-9:0], 8'h00};
          tx_idx_d = tx_idx_q + 3'h1;
          if (tx_idx_q == PDU_LAST_IDX) begin
            tx_state_d = TX_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_state_q <= TX_IDLE;
      frame_q <= '0;
      tx_idx_q <= 3'h0;
      inst_q <= '0;
    end else begin
      tx_state_q <= tx_state_d;
      frame_q <= frame_d;
      tx_idx_q <= tx_idx_d;
      inst_q <= inst_d;
    end
  end

  assign tx_valid = tx_state_q == TX_SEND;
  assign tx_beat.data = frame_q[8*PDU_BYTES-1 -: 8];
  assign tx_beat.last = tx_valid && tx_idx_q == PDU_LAST_IDX;
  assign tx_instance = inst_q;

  // ----------------------------------------------------------------
  // Receive side
  // ----------------------------------------------------------------
  logic pdu_ok; // Valid PDU just ended
  logic pdu_dci; // It carried a clear
  logic pdu_minute; // It announced a 1 minute period

  csf_rx_parser parser (
    .clock(clock),
    .rst_n(rst_n),
    .rx_valid(rx_valid),
    .rx_beat(rx_beat),
    .local_level(local_level),
    .pdu_ok(pdu_ok),
    .pdu_dci(pdu_dci),
    .pdu_minute(pdu_minute)
  );

  logic rem_q, rem_d; // Remote fault held
  logic rx_min_q, rx_min_d; // Sender's last period
  logic [TIMER_W-1:0] to_cnt_q, to_cnt_d; // Ticks since last PDU
  logic [TIMER_W-1:0] to_limit; // Silence that clears

  // Aggregated clients time out on our own interval
  always_comb begin
    if (client_is_lag) begin
      to_limit = cfg_timeout;
    end else if (rx_min_q) begin
      to_limit = TIMEOUT_MIN_MS;
    end else begin
      to_limit = TIMEOUT_SEC_MS;
    end
  end

  // Remote fault: a received fault wins over a same-cycle timeout
  always_comb begin
    rem_d = rem_q;
    rx_min_d = rx_min_q;
    to_cnt_d = to_cnt_q;
    if (rem_q && tick) begin
      if (to_cnt_q >= to_limit - 1'b1) begin
        rem_d = 1'b0;
        to_cnt_d = '0;
      end else begin
        to_cnt_d = to_cnt_q + 1'b1;
      end
    end
    if (pdu_ok) begin
      to_cnt_d = '0;
      rx_min_d = pdu_minute;
      rem_d = !pdu_dci;
    end
    // A failed remote end point releases the client port
    if (!remote_mep_up) begin
      rem_d = 1'b0;
      to_cnt_d = '0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rem_q <= 1'b0;
      rx_min_q <= 1'b0;
      to_cnt_q <= '0;
    end else begin
      rem_q <= rem_d;
      rx_min_q <= rx_min_d;
      to_cnt_q <= to_cnt_d;
    end
  end

  assign remote_fault = rem_q;
  assign egress_oper_up = ~rem_q;

endmodule : csf_oam_framer

`default_nettype wire

/* File: shared/csf_pkg.sv */
/*
  Shared constants and types for the client-signal-fail framer.
  Assumes one 125 MHz system clock; PDU bytes move as one byte a beat.
*/
`default_nettype none

package csf_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLOCK_HZ = 125_000_000;
  localparam int unsigned TICK_TIME_MS = 1;
  // Clock cycles in one millisecond tick
  localparam int unsigned TICK_CYCLES_DEFAULT = CLOCK_HZ / 1000 * TICK_TIME_MS;
  localparam int unsigned TICK_CNT_W = 17;
  // Transmit periods, in seconds
  localparam int unsigned PERIOD_SEC_S = 1;
  localparam int unsigned PERIOD_MIN_S = 60;
  localparam int unsigned TIMER_W = 18;
  // Periods and 3.5-period timeouts, in ms ticks
  localparam logic [17:0] PERIOD_SEC_MS = 18'(PERIOD_SEC_S * 1000);
  localparam logic [17:0] PERIOD_MIN_MS = 18'(PERIOD_MIN_S * 1000);
  localparam logic [17:0] TIMEOUT_SEC_MS = 18'(PERIOD_SEC_S * 1000 * 7 / 2);
  localparam logic [17:0] TIMEOUT_MIN_MS = 18'(PERIOD_MIN_S * 1000 * 7 / 2);

  // ----------------------------------------------------------------
  // PDU fields
  // ----------------------------------------------------------------
  localparam logic [4:0] PDU_VERSION = 5'h00;
  localparam logic [7:0] PDU_OPCODE = 8'h34;
  localparam logic [7:0] PDU_TLV_OFFSET = 8'h00;
  localparam logic [7:0] PDU_END_TLV = 8'h00;
  localparam logic [2:0] PDU_LAST_IDX = 3'h4;
  localparam int unsigned PDU_BYTES = 5;
  // Defect type codes, flags bits 6 to 4
  localparam logic [2:0] DEFECT_LOS = 3'h0;
  localparam logic [2:0] DEFECT_FDI = 3'h1;
  localparam logic [2:0] DEFECT_RDI = 3'h2;
  localparam logic [2:0] DEFECT_DCI = 3'h3;
  // Period codes, flags bits 3 to 1
  localparam logic [2:0] PERIOD_CODE_SEC = 3'h4;
  localparam logic [2:0] PERIOD_CODE_MIN = 3'h6;
  // End point instance space
  localparam int unsigned INSTANCE_W = 13;
  localparam int unsigned INSTANCE_MAX = 8192;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // Flags octet layout
  typedef struct packed {
    logic spare_hi;
    logic [2:0] defect;
    logic [2:0] period;
    logic spare_lo;
  } csf_flags_type;

  // One byte beat of a PDU stream
  typedef struct packed {
    logic [7:0] data;
    logic last;
  } byte_beat_type;

  // Transmit sequencer states
  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SEND = 2'b10
  } tx_state_type;

endpackage : csf_pkg

`default_nettype wire

/* File: design/csf_rx_parser.sv */
/*
  Receive parser: checks one PDU a frame, byte by byte.
  Assumes beats arrive without back-pressure, one byte a valid cycle.
*/
`default_nettype none

module csf_rx_parser import csf_pkg::*; (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic rx_valid,
  input wire byte_beat_type rx_beat,
  input wire logic [2:0] local_level,
  output logic pdu_ok,
  output logic pdu_dci,
  output logic pdu_minute
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [2:0] idx_q, idx_d; // Byte index within the frame
  logic bad_q, bad_d; // Frame already judged bad
  csf_flags_type flags_q, flags_d; // Captured flags octet
  logic ok_q, ok_d; // One-cycle accept pulse
  logic byte_bad; // Current byte fails its check

  // Per-byte field checks
  always_comb begin
    byte_bad = 1'b0;
    unique case (idx_q)
      3'h0: byte_bad = rx_beat.data != {local_level, PDU_VERSION};
      3'h1: byte_bad = rx_beat.data != PDU_OPCODE;
      3'h2: byte_bad = (rx_beat.data[3:1] != PERIOD_CODE_SEC) &&
                       (rx_beat.data[3:1] != PERIOD_CODE_MIN);
      3'h3: byte_bad = 1'b0;
      3'h4: byte_bad = !rx_beat.last || rx_beat.data != PDU_END_TLV;
      default: byte_bad = 1'b1; // Too long
    endcase
  end

  // Next-state: frame walk and accept decision
  always_comb begin
    idx_d = idx_q;
    bad_d = bad_q;
    flags_d = flags_q;
    ok_d = 1'b0;
    if (rx_valid) begin
      if (idx_q == 3'h2) begin
        flags_d = rx_beat.data;
      end
      if (rx_beat.last) begin
        // Short frames never reach the end-marker check
        ok_d = !bad_q && !byte_bad && idx_q == PDU_LAST_IDX;
        idx_d = 3'h0;
        bad_d = 1'b0;
      end else begin
        bad_d = bad_q | byte_bad;
        // Saturate so an overlong frame stays bad
        if (idx_q != 3'h5) begin
          idx_d = idx_q + 3'h1;
        end
      end
    end
  end

  // Registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      idx_q <= 3'h0;
      bad_q <= 1'b0;
      flags_q <= '0;
      ok_q <= 1'b0;
    end else begin
      idx_q <= idx_d;
      bad_q <= bad_d;
      flags_q <= flags_d;
      ok_q <= ok_d;
    end
  end

  assign pdu_ok = ok_q;
  assign pdu_dci = flags_q.defect == DEFECT_DCI;
  assign pdu_minute = flags_q.period == PERIOD_CODE_MIN;

endmodule : csf_rx_parser

`default_nettype wire

/* File: sim/csf_oam_framer_properties.sv */
/* Port checker for the client-signal-fail framer.
   Assumes it is bound into csf_oam_framer with one clock. */
`default_nettype none
module csf_checker import csf_pkg::*; #(
  parameter int unsigned TICK_CYCLES = 10
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic csf_enable,
  input wire logic [2:0] local_level,
  input wire logic client_link_up,
  input wire logic local_mep_up,
  input wire logic remote_mep_up,
  input wire logic tx_valid,
  input wire byte_beat_type tx_beat,
  input wire logic tx_ready,
  input wire logic rx_valid,
  input wire byte_beat_type rx_beat,
  input wire logic remote_fault,
  input wire logic egress_oper_up
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------
  // Beat position
  // ------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic [2:0] idx_q, idx_d; // Index of the beat now offered
  // Advance on each accepted beat, back to zero after the last
  always_comb begin
    idx_d = idx_q;
    if (tx_valid && tx_ready) idx_d = tx_beat.last ? 3'h0 : idx_q + 3'h1;
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) idx_q <= 3'h0;
    else idx_q <= idx_d;
  end
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  property p_level;
    tx_valid && idx_q == 3'h0 |-> tx_beat.data == {local_level, 5'h00};
  endproperty
  a_level: assert property (p_level) else $error("level byte wrong");
  property p_opcode;
    tx_valid && idx_q == 3'h1 |-> tx_beat.data == 8'h34;
  endproperty
  a_opcode: assert property (p_opcode) else $error("opcode wrong");
  property p_flags;
    tx_valid && idx_q == 3'h2 |-> !tx_beat.data[7] && !tx_beat.data[0]
      && tx_beat.data[6:4] <= 3'h3 && tx_beat.data[3:1] inside {3'h4, 3'h6};
  endproperty
  a_flags: assert property (p_flags) else $error("flags wrong");
  property p_offset;
    tx_valid && idx_q == 3'h3 |-> tx_beat.data == 8'h00 && !tx_beat.last;
  endproperty
  a_offset: assert property (p_offset) else $error("offset wrong");
  property p_end;
    tx_valid && (idx_q == 3'h4 || tx_beat.last) |-> tx_beat.data == 8'h00
      && tx_beat.last && idx_q == 3'h4;
  endproperty
  a_end: assert property (p_end) else $error("end octet wrong");
  property p_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_beat);
  endproperty
  a_hold: assert property (p_hold) else $error("beat dropped");
  property p_gap;
    tx_valid && tx_ready && tx_beat.last |=> !tx_valid;
  endproperty
  a_gap: assert property (p_gap) else $error("no idle after frame");
  property p_mep;
    !tx_valid && !(local_mep_up && remote_mep_up) |=> !tx_valid;
  endproperty
  a_mep: assert property (p_mep) else $error("frame while end point down");
  property p_start;
    $fell(client_link_up) && csf_enable && local_mep_up && remote_mep_up
      && !tx_valid |-> ##[1:3] tx_valid;
  endproperty
  a_start: assert property (p_start) else $error("fault frame late");
  property p_egress;
    egress_oper_up == !remote_fault;
  endproperty
  a_egress: assert property (p_egress) else $error("egress state wrong");
  property p_rise;
    $rose(remote_fault) |-> $past(rx_valid, 2) && $past(rx_beat.last, 2);
  endproperty
  a_rise: assert property (p_rise) else $error("fault without frame");
endmodule : csf_checker
bind csf_oam_framer csf_checker #(.TICK_CYCLES(TICK_CYCLES)) chk (
  .clock(clock), .rst_n(rst_n), .csf_enable(csf_enable), .local_level(local_level),
  .client_link_up(client_link_up), .local_mep_up(local_mep_up),
  .remote_mep_up(remote_mep_up), .tx_valid(tx_valid), .tx_beat(tx_beat),
  .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_beat(rx_beat),
  .remote_fault(remote_fault), .egress_oper_up(egress_oper_up));
`default_nettype wire

/* File: sim/csf_peer_model.sv */
/* Peer end point: sinks sent frames, sends commanded PDUs.
   Assumes the bench calls send_pdu just after a clock edge. */
`default_nettype none
module csf_peer_model import csf_pkg::*; (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic stall,
  input wire logic tx_valid,
  input wire byte_beat_type tx_beat,
  output logic tx_ready,
  output logic rx_valid,
  output byte_beat_type rx_beat
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cap [0:4]; // Bytes of the latest frame
  int frames = 0; // Frames fully received
  int n = 0; // Byte position
  int cyc = 0; // Free cycle count for slow acceptance
  initial begin
    rx_valid = 1'b0;
    rx_beat = '0;
  end
  // Slow mode takes one beat in three, to stress the hold rule
  always @(posedge clock) cyc <= cyc + 1;
  assign tx_ready = !stall || (cyc % 3 == 0);
  // Capture accepted beats
  always @(posedge clock) begin
    if (rst_n && tx_valid && tx_ready) begin
      cap[n % 5] <= tx_beat.data;
      n <= tx_beat.last ? 0 : n + 1;
      if (tx_beat.last) frames <= frames + 1;
    end
  end
  // Send one PDU of five beats, then release the line
  task automatic send_pdu(input logic [39:0] pdu);
    for (int i = 0; i < 5; i++) begin
      @(posedge clock);
      #1;
      rx_valid = 1'b1;
      rx_beat = {pdu[39 - 8 * i -: 8], i == 4};
    end
    @(posedge clock);
    #1;
    rx_valid = 1'b0;
    rx_beat = ~rx_beat; // Released line shows no stale byte
  endtask : send_pdu
endmodule : csf_peer_model
`default_nettype wire

/* File: sim/csf_oam_framer_test.sv */
/* Self-checking bench for the framer.
   Assumes a shortened tick of 10 cycles; the checker is bound. */
`default_nettype none
module client_signal_fail_oam_framer_test import csf_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic clock = 1'b0, rst_n = 1'b0, csf_enable = 1'b1, period_minute = 1'b0;
  logic dci_on_clear = 1'b0, client_is_lag = 1'b0, client_link_up = 1'b1;
  logic local_mep_up = 1'b1, remote_mep_up = 1'b1, stall = 1'b0;
  logic [2:0] local_level = 3'h5, defect_cfg = 3'h0;
  logic [12:0] instance_id = 13'h0007, tx_instance;
  logic tx_valid, tx_ready, rx_valid, remote_fault, egress_oper_up;
  byte_beat_type tx_beat, rx_beat;
  int mismatches = 0, samples_checked = 0, cycles = 0;
  csf_oam_framer #(.TICK_CYCLES(10)) DUT (.clock(clock), .rst_n(rst_n),
    .csf_enable(csf_enable), .local_level(local_level), .defect_cfg(defect_cfg),
    .period_minute(period_minute), .dci_on_clear(dci_on_clear),
    .client_is_lag(client_is_lag), .instance_id(instance_id),
    .client_link_up(client_link_up), .local_mep_up(local_mep_up),
    .remote_mep_up(remote_mep_up), .tx_valid(tx_valid), .tx_beat(tx_beat),
    .tx_instance(tx_instance), .tx_ready(tx_ready), .rx_valid(rx_valid),
    .rx_beat(rx_beat), .remote_fault(remote_fault), .egress_oper_up(egress_oper_up));
  csf_peer_model peer (.clock(clock), .rst_n(rst_n), .stall(stall),
    .tx_valid(tx_valid), .tx_beat(tx_beat), .tx_ready(tx_ready),
    .rx_valid(rx_valid), .rx_beat(rx_beat));
  always #4 clock = ~clock;
  // Hang guard, a little above the expected run length
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      mismatches++;
      complete_run();
    end
  end
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic check_val(input string what, input logic [31:0] exp,
                           input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check_val
  task automatic tick(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask : tick
  // Bounded wait for the peer to hold a frame count
  task automatic wait_frames(input int want);
    for (int i = 0; i < 60 && peer.frames < want; i++) tick(1);
  endtask : wait_frames
  function automatic logic [39:0] pdu(input logic [2:0] lvl, input logic [7:0] op,
                                      input logic [2:0] ty, input logic [2:0] per);
    return {lvl, 5'h00, op, 1'b0, ty, per, 1'b0, 16'h0000};
  endfunction : pdu
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  // Defect settings 0 to 3 at both periods; settings 1 and 3 with a stalled sink
  task automatic test_tx();
    int base;
    logic [2:0] kind;
    for (int k = 0; k < 8; k++) begin
      defect_cfg = 3'(k % 4);
      period_minute = k[2];
      stall = k[0];
      instance_id = 13'(k * 1000 + 7);
      kind = (k % 4 == 3) ? 3'h0 : 3'(k % 4); // DCI setting sends loss
      base = peer.frames;
      client_link_up = 1'b0;
      wait_frames(base + 1);
      check_val("frames", base + 1, peer.frames);
      check_val("byte0", {local_level, 5'h00}, peer.cap[0]);
      check_val("opcode", 8'h34, peer.cap[1]);
      check_val("flags", {1'b0, kind, k[2] ? 3'h6 : 3'h4, 1'b0}, peer.cap[2]);
      check_val("offset", 8'h00, peer.cap[3]);
      check_val("end", 8'h00, peer.cap[4]);
      check_val("instance", instance_id, tx_instance);
      client_link_up = 1'b1;
      tick(20);
    end
    stall = 1'b0;
    period_minute = 1'b0;
    $display("test_tx done");
  endtask : test_tx
  // Recovery by clear PDU, then by silence
  task automatic test_clear();
    int base = peer.frames;
    dci_on_clear = 1'b1;
    client_link_up = 1'b0;
    wait_frames(base + 1);
    client_link_up = 1'b1;
    wait_frames(base + 2);
    check_val("dci flags", 8'h38, peer.cap[2]);
    dci_on_clear = 1'b0;
    client_link_up = 1'b0;
    wait_frames(base + 3);
    client_link_up = 1'b1;
    tick(60);
    check_val("silent clear", base + 3, peer.frames);
    $display("test_clear done");
  endtask : test_clear
  // Second frame one period after the first
  task automatic test_period();
    int base = peer.frames;
    client_link_up = 1'b0;
    wait_frames(base + 1);
    tick(9950);
    check_val("early", base + 1, peer.frames);
    tick(100);
    check_val("repeat", base + 2, peer.frames);
    client_link_up = 1'b1;
    tick(20);
    $display("test_period done");
  endtask : test_period
  // Either end point down, or sending switched off, blocks sending
  task automatic test_mep();
    int base;
    for (int m = 0; m < 3; m++) begin
      base = peer.frames;
      local_mep_up = (m != 0);
      remote_mep_up = (m != 1);
      csf_enable = (m != 2); // Last pass: both up, sending disabled
      client_link_up = 1'b0;
      tick(60);
      check_val("blocked", base, peer.frames);
      client_link_up = 1'b1;
      tick(5);
    end
    local_mep_up = 1'b1;
    remote_mep_up = 1'b1;
    csf_enable = 1'b1;
    $display("test_mep done");
  endtask : test_mep
  // Received PDUs: accepted faults, clears and refusals
  task automatic test_rx();
    logic [39:0] p [7];
    logic e [7] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
    p = '{pdu(3'h5, 8'h34, 3'h0, 3'h4), pdu(3'h5, 8'h34, 3'h3, 3'h4),
          pdu(3'h5, 8'h35, 3'h2, 3'h4), pdu(3'h5, 8'h34, 3'h1, 3'h0),
          pdu(3'h4, 8'h34, 3'h1, 3'h4), pdu(3'h5, 8'h34, 3'h2, 3'h6),
          pdu(3'h5, 8'h34, 3'h3, 3'h6)};
    for (int i = 0; i < 7; i++) begin
      peer.send_pdu(p[i]);
      tick(3);
      check_val("fault", e[i], remote_fault);
      check_val("egress", !e[i], egress_oper_up);
    end
    $display("test_rx done");
  endtask : test_rx
  // Silence clears after 3.5 periods, lag uses own period
  task automatic test_timeout();
    for (int g = 0; g < 2; g++) begin
      client_is_lag = g[0];
      peer.send_pdu(pdu(3'h5, 8'h34, 3'h0, g[0] ? 3'h6 : 3'h4));
      tick(34900);
      check_val("held", 1'b1, remote_fault);
      tick(200);
      check_val("timed out", 1'b0, remote_fault);
    end
    $display("test_timeout done");
  endtask : test_timeout
  task automatic complete_run();
    $display("checked %0d mismatched %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    tick(16);
    rst_n = 1'b1;
    tick(2);
    test_tx();
    test_clear();
    test_period();
    test_mep();
    test_rx();
    test_timeout();
    complete_run();
  end
endmodule : client_signal_fail_oam_framer_test
`default_nettype wire
